// [bench/imre_checker.sv]
`timescale 1ns/1ns
module imre_checker
#(
  parameter PC_W = 15
)
(
  input wire            CLK,
  input wire            RST,
  input wire            GO,
  input wire            BUSY,
  input wire            DONE,
  input wire            IRQ_RET,
  input wire            MEM_WE,
  input wire            STACK_POP,
  input wire            RESET_REQ,
  input wire            RESET_FLAG_N,
  input wire            Z,
  input wire [2:0]      OP,
  input wire [PC_W-1:0] PC,
  input wire [PC_W-1:0] STACK_TOP,
  input wire [7:0]      OPTION_REG,
  input wire [7:0]      IRQ_CTRL,
  input wire [7:0]      W,
  input wire [15:0]     PTR0,
  input wire [15:0]     PTR1
);
  // an op is taken only while the block is idle
  wire t = GO && !BUSY;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_ret_pop: assert property (t && OP == 3'h7
    |=> STACK_POP ##1 DONE) else $error("bad return timing");
  a_ret_pc: assert property (STACK_POP
    |=> PC == $past(STACK_TOP)) else $error("pc not from stack");
  a_gie_set: assert property (t && OP == 3'h7 && IRQ_RET
    |=> ##1 IRQ_CTRL[7]) else $error("global enable not set");
  a_opt_copy: assert property (t && OP == 3'h5
    |=> DONE && OPTION_REG == $past(W) && $stable(W)) else $error("opt");
  a_sw_reset: assert property (t && OP == 3'h6
    |=> RESET_REQ && !RESET_FLAG_N) else $error("soft reset");
  a_nop_quiet: assert property (t && OP == 3'h0
    |=> DONE && $stable(W) && $stable(Z) && $stable(PTR0)) else $error("nop");
  a_flag_keep: assert property (t && OP == 3'h1
    |=> MEM_WE && $stable(Z)) else $error("flag moved on write");
  a_k_ptr: assert property (t && (OP == 3'h3 || OP == 3'h4)
    |=> $stable(PTR0) && $stable(PTR1)) else $error("pointer moved");
  cover property (STACK_POP);
  cover property (t && OP == 3'h5);
  cover property (t && OP == 3'h6);
endmodule
bind imre_exec imre_checker #(.PC_W(PC_W)) chk_i (
  .CLK(CLK), .RST(RST), .GO(GO), .BUSY(BUSY), .DONE(DONE),
  .IRQ_RET(IRQ_RET), .MEM_WE(MEM_WE), .STACK_POP(STACK_POP),
  .RESET_REQ(RESET_REQ), .RESET_FLAG_N(RESET_FLAG_N), .Z(Z), .OP(OP),
  .PC(PC), .STACK_TOP(STACK_TOP), .OPTION_REG(OPTION_REG),
  .IRQ_CTRL(IRQ_CTRL), .W(W), .PTR0(PTR0), .PTR1(PTR1));

// [bench/imre_exec_test.sv]
`timescale 1ns/1ns
module imre_exec_test;
  reg        clk = 0, rst = 1, go = 0, ir = 0, sel = 0;
  reg [14:0] pcv = 0;
  reg [2:0]  op = 0;
  reg [1:0]  md = 0;
  reg [5:0]  off = 0;
  reg [7:0]  rd = 8'hA5;
  reg [14:0] stack_top = 15'h1234;
  wire       busy, done, we, pop, rq, rfn, z;
  wire [14:0] pc;
  wire [15:0] adr, p0, p1;
  wire [7:0] wd, opt, icr, w;
  integer    n_fail = 0, samples_checked = 0, cyc = 0;
  imre_exec uut (.CLK(clk), .RST(rst), .GO(go), .OP(op), .PTR_SEL(sel),
    .MODE(md), .OFFSET(off), .IRQ_RET(ir), .MEM_RDATA(rd), .STACK_TOP(stack_top),
    .BUSY(busy), .DONE(done), .PC(pc), .MEM_ADDR(adr), .MEM_WDATA(wd),
    .MEM_WE(we), .STACK_POP(pop), .RESET_REQ(rq), .RESET_FLAG_N(rfn),
    .OPTION_REG(opt), .IRQ_CTRL(icr), .W(w), .Z(z), .PTR0(p0), .PTR1(p1));
  always #20 clk = ~clk;
  // hang guard: a run that reaches 3000 cycles is counted as a failure
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail = n_fail + 1;
      test_done;
    end
  end
  task test_done;
  begin
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task chk(input string n, input [15:0] s, e);
  begin
    samples_checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  end
  endtask
  // one op, then wait for its done pulse (bounded)
  task op1(input [2:0] o, input [1:0] m, input [5:0] k);
    integer i;
  begin
    @(posedge clk);
    op <= o;
    md <= m;
    off <= k;
    go <= 1;
    @(posedge clk);
    go <= 0;
    i = 0;
    // one-cycle ops show done right after the edge that takes them
    #1;
    chk("busy", busy, o == 3'h2 || o == 3'h4 || o == 3'h7);
    while (done !== 1'b1 && i < 9)
    begin
      @(posedge clk);
      #1;
      i = i + 1;
    end
    chk("done", done, 1);
  end
  endtask
  task mv(input [2:0] o, input [1:0] m, input [5:0] k, input [15:0] a, p);
  begin
    op1(o, m, k);
    chk("adr", adr, a);
    chk("ptr", sel ? p1 : p0, p);
  end
  endtask
  task t_modes;
  begin
    @(posedge clk);
    rd <= 8'h00;
    sel <= 1;
    mv(3'h2, 2'h2, 6'h00, 16'h0000, 16'h0001);
    chk("z", z, 1);
    mv(3'h1, 2'h0, 6'h00, 16'h0002, 16'h0002);
    chk("z", z, 1);
    chk("p0", p0, 16'h0000);
    @(posedge clk);
    rd <= 8'hA5;
    sel <= 0;
    mv(3'h2, 2'h1, 6'h00, 16'hFFFF, 16'hFFFF);
    chk("w", w, rd);
    mv(3'h1, 2'h2, 6'h00, 16'hFFFF, 16'h0000);
    chk("wdata", wd, rd);
    mv(3'h1, 2'h0, 6'h00, 16'h0001, 16'h0001);
    mv(3'h1, 2'h3, 6'h00, 16'h0001, 16'h0000);
    mv(3'h3, 2'h0, 6'h3F, 16'hFFFF, 16'h0000);
    mv(3'h4, 2'h0, 6'h1F, 16'h001F, 16'h0000);
    $display("t_modes done");
  end
  endtask
  task t_misc;
  begin
    op1(3'h5, 2'h0, 6'h00);
    chk("opt", opt, rd);
    pcv = pc;
    op1(3'h0, 2'h0, 6'h00);
    chk("w", w, rd);
    chk("pc", pc, pcv + 1'b1);
    @(posedge clk);
    ir <= 1;
    op1(3'h7, 2'h0, 6'h00);
    chk("pc", pc, stack_top);
    chk("gie", icr[7], 1);
    @(posedge clk);
    ir <= 0;
    stack_top <= 15'h0042;
    op1(3'h7, 2'h0, 6'h00);
    chk("pc", pc, 15'h0042);
    op1(3'h6, 2'h0, 6'h00);
    chk("rfn", rfn, 0);
    chk("rq", rq, 1);
    $display("t_misc done");
  end
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 0;
    t_modes;
    t_misc;
    test_done;
  end
endmodule

// [verilog/imre_exec.v]
// How it works
// - mode field: preinc, predec, postinc, postdec
// - pre modes update pointer before transfer
// - window access goes to pointed address
// - pointer is 16 bits and wraps
// - pointer update leaves status flags alone
// - option load copies working register
// - software reset requests reset, clears flag
// - irq return pops stack into counter
// - irq return sets global enable bit
// - irq return takes two cycles
// - subroutine return pops stack into counter
// - subroutine return takes two cycles
// - offset form uses pointer plus signed k
`timescale 1ns/1ns
`include "imre_map.vh"
module imre_exec
#(
  parameter PC_W = 15
)
(
  input  wire            CLK,
  input  wire            RST,
  input  wire            GO,
  input  wire [2:0]      OP,
  input  wire            PTR_SEL,
  input  wire [1:0]      MODE,
  input  wire [5:0]      OFFSET,
  input  wire            IRQ_RET,
  input  wire [7:0]      MEM_RDATA,
  input  wire [PC_W-1:0] STACK_TOP,
  output wire            BUSY,
  output reg             DONE,
  output reg  [PC_W-1:0] PC,
  output reg  [15:0]     MEM_ADDR,
  output reg  [7:0]      MEM_WDATA,
  output reg             MEM_WE,
  output reg             STACK_POP,
  output reg             RESET_REQ,
  output reg             RESET_FLAG_N,
  output reg  [7:0]      OPTION_REG,
  output reg  [7:0]      IRQ_CTRL,
  output reg  [7:0]      W,
  output reg             Z,
  output wire [15:0]     PTR0,
  output wire [15:0]     PTR1
);

  // one-hot states; return and read hold a second cycle
  localparam S_IDLE = 3'b001;
  localparam S_RET1 = 3'b010;
  localparam S_RD   = 3'b100;

  // two pointers, each built by the loop further down
  localparam N_PTR  = 2;

  // sequencer state and its next value
  reg  [2:0]       state_q;
  reg  [2:0]       state_d;
  // return source, held over the second return cycle
  reg              ret_irq_q;

  // pointer path and effective addresses
  wire [31:0]      ptr_bus;
  wire [15:0]      ptr_cur;
  wire [15:0]      ptr_upd;
  wire             pre;
  wire [15:0]      ea_mode;
  wire [15:0]      ea_off;
  wire [15:0]      ea;

  // accepted operations, one strobe per class
  wire             take;
  wire             take_nop;
  wire             take_wr;
  wire             take_rd;
  wire             take_mode;
  wire             take_opt;
  wire             take_rst;
  wire             take_ret;
  wire             done_d;
  wire [PC_W-1:0]  pc_one;

  // pointer step; 16-bit add and subtract wrap at both ends
  function [15:0] step;
    input [15:0] p;
    input        dec;
    begin
      if (dec)
        step = p - `IMRE_ONE16;
      else
        step = p + `IMRE_ONE16;
    end
  endfunction

  // window write in either addressing form
  function is_write;
    input [2:0] o;
    begin
      is_write = (o == `IMRE_OP_WR_PTR) || (o == `IMRE_OP_WR_OFF);
    end
  endfunction

  // window read in either addressing form
  function is_read;
    input [2:0] o;
    begin
      is_read = (o == `IMRE_OP_RD_PTR) || (o == `IMRE_OP_RD_OFF);
    end
  endfunction

  // offset form: address from pointer plus k, pointer kept
  function uses_off;
    input [2:0] o;
    begin
      uses_off = (o == `IMRE_OP_WR_OFF) || (o == `IMRE_OP_RD_OFF);
    end
  endfunction

  // mode form: pointer steps as part of the move
  function uses_mode;
    input [2:0] o;
    begin
      uses_mode = (o == `IMRE_OP_WR_PTR) || (o == `IMRE_OP_RD_PTR);
    end
  endfunction

  // selected pointer and its stepped value
  assign ptr_cur = PTR_SEL ? PTR1 : PTR0;
  assign ptr_upd = step(ptr_cur, MODE[`IMRE_MODE_DEC_BIT]);
  // pre modes address the stepped value, post modes the old one
  assign pre     = ~MODE[`IMRE_MODE_POST_BIT];
  assign ea_mode = pre ? ptr_upd : ptr_cur;
  // sign-extended k; the sum wraps like the pointer itself
  assign ea_off  = ptr_cur +
                   {{`IMRE_OFF_EXT{OFFSET[`IMRE_OFF_MSB]}}, OFFSET};
  assign ea      = uses_off(OP) ? ea_off : ea_mode;

  // a request is taken only while idle; GO during BUSY is ignored
  assign take      = GO && (state_q == S_IDLE);
  assign take_nop  = take && (OP == `IMRE_OP_NOP);
  assign take_wr   = take && is_write(OP);
  assign take_rd   = take && is_read(OP);
  assign take_mode = take && uses_mode(OP);
  assign take_opt  = take && (OP == `IMRE_OP_OPTION);
  assign take_rst  = take && (OP == `IMRE_OP_RESET);
  assign take_ret  = take && (OP == `IMRE_OP_RETURN);

  // one-cycle ops finish at once, the others in their second cycle
  assign done_d = take_nop || take_wr || take_opt || take_rst ||
                  (state_q == S_RET1) || (state_q == S_RD);
  assign pc_one = {{(PC_W-1){1'b0}}, 1'b1};
  assign BUSY   = (state_q != S_IDLE);

  // next state
  always @*
  begin
    state_d = state_q;
    case (state_q)
      S_IDLE:
      begin
        if (take_rd)
          state_d = S_RD;
        else if (take_ret)
          state_d = S_RET1;
      end
      S_RET1:
        state_d = S_IDLE;
      S_RD:
        state_d = S_IDLE;
      default:
        state_d = S_IDLE;
    endcase
  end

  // state register
  always @(posedge CLK)
  begin
    if (RST)
      state_q <= S_IDLE;
    else
      state_q <= state_d;
  end

  // one-cycle pulses toward memory, stack and reset logic
  always @(posedge CLK)
  begin
    if (RST)
    begin
      DONE      <= 1'b0;
      MEM_WE    <= 1'b0;
      STACK_POP <= 1'b0;
      RESET_REQ <= 1'b0;
    end
    else
    begin
      DONE      <= done_d;
      MEM_WE    <= take_wr;
      STACK_POP <= take_ret;
      RESET_REQ <= take_rst;
    end
  end

  // return source; only read in the second return cycle
  always @(posedge CLK)
  begin
    if (RST)
      ret_irq_q <= 1'b0;
    else if (take_ret)
      ret_irq_q <= IRQ_RET;
  end

  // counter: the stack wins in the second return cycle
  always @(posedge CLK)
  begin
    if (RST)
      PC <= {PC_W{1'b0}};
    else if (state_q == S_RET1)
      PC <= STACK_TOP;
    else if (state_q == S_RD)
      PC <= PC + pc_one;
    else if (take_nop || take_wr || take_opt)
      PC <= PC + pc_one;
  end

  // memory port; the address stands until the next move
  always @(posedge CLK)
  begin
    if (RST)
    begin
      MEM_ADDR  <= `IMRE_PTR_RST;
      MEM_WDATA <= `IMRE_ZERO8;
    end
    else
    begin
      if (take_wr || take_rd)
        MEM_ADDR <= ea;
      if (take_wr)
        MEM_WDATA <= W;
    end
  end

  // option and interrupt control registers
  always @(posedge CLK)
  begin
    if (RST)
    begin
      OPTION_REG <= `IMRE_OPT_RST;
      IRQ_CTRL   <= `IMRE_ICR_RST;
    end
    else
    begin
      if (take_opt)
        OPTION_REG <= W;
      if ((state_q == S_RET1) && ret_irq_q)
        IRQ_CTRL[`IMRE_IRQ_EN_BIT] <= 1'b1;
    end
  end

  // working register and zero flag change only on a window read
  always @(posedge CLK)
  begin
    if (RST)
    begin
      W <= `IMRE_W_RST;
      Z <= 1'b0;
    end
    else if (state_q == S_RD)
    begin
      // memory answers one cycle after the address
      W <= MEM_RDATA;
      Z <= (MEM_RDATA == `IMRE_ZERO8);
    end
  end

  // reset-cause flag, low after a software reset; limitation: the
  // outer reset logic must not route that reset back through RST,
  // or the cause is lost here
  always @(posedge CLK)
  begin
    if (RST)
      RESET_FLAG_N <= 1'b1;
    else if (take_rst)
      RESET_FLAG_N <= 1'b0;
  end

  // one pointer register per index; k forms leave them alone
  genvar g;
  generate
    for (g = 0; g < N_PTR; g = g + 1)
    begin : g_ptr
      reg  [15:0] ptr_q;
      wire        sel_me;
      assign sel_me = (g == 0) ? ~PTR_SEL : PTR_SEL;
      always @(posedge CLK)
      begin
        if (RST)
          ptr_q <= `IMRE_PTR_RST;
        else if (take_mode && sel_me)
          ptr_q <= ptr_upd;
      end
      assign ptr_bus[g*`IMRE_PTR_W +: `IMRE_PTR_W] = ptr_q;
    end
  endgenerate

  // pointer outputs
  assign PTR0 = ptr_bus[`IMRE_PTR_W-1:0];
  assign PTR1 = ptr_bus[2*`IMRE_PTR_W-1:`IMRE_PTR_W];
endmodule

// [verilog/imre_map.vh]
`ifndef IMRE_MAP_VH
`define IMRE_MAP_VH
// operation codes presented on OP
`define IMRE_OP_NOP      3'h0
`define IMRE_OP_WR_PTR   3'h1
`define IMRE_OP_RD_PTR   3'h2
`define IMRE_OP_WR_OFF   3'h3
`define IMRE_OP_RD_OFF   3'h4
`define IMRE_OP_OPTION   3'h5
`define IMRE_OP_RESET    3'h6
`define IMRE_OP_RETURN   3'h7
// pointer mode field codes
`define IMRE_MODE_PREINC  2'h0
`define IMRE_MODE_PREDEC  2'h1
`define IMRE_MODE_POSTINC 2'h2
`define IMRE_MODE_POSTDEC 2'h3
// mode field bits: bit0 picks decrement, bit1 picks post
`define IMRE_MODE_DEC_BIT  0
`define IMRE_MODE_POST_BIT 1
// offset sign bit and extension to pointer width
`define IMRE_OFF_MSB     5
`define IMRE_OFF_EXT     10
`define IMRE_PTR_W       16
// field positions and reset values
`define IMRE_IRQ_EN_BIT  7
`define IMRE_ZERO8       8'h00
`define IMRE_PTR_RST     16'h0000
`define IMRE_OPT_RST     8'hFF
`define IMRE_ICR_RST     8'h00
`define IMRE_W_RST       8'h00
`define IMRE_ONE16       16'h0001
`endif
